/* core/emc_core.sv */
// Error latching, error mask, summary bit and reading framer with EOI
//
// Contract
// - Every error latches regardless of mask
// - Mask bit only gates the summary bit
// - Mask value is weighted sum, bits 0..14
// - Bits 0..7: hardware to memory faults
// - Bits 8..14: overload to system fault
// - Mask is all ones after reset, defaults
// - Mask query returns present mask
// - Mode OFF never asserts EOI
// - Mode ON: EOI on last reading only
// - Mode ALWAYS: EOI every reading's final byte
// - OFF after reset, ALWAYS on defaults
// - Direct ASCII readings end in cr lf only
// - Recalled ASCII group: commas, one cr lf
// - No commas direct, implied, or binary
// - High speed turns ALWAYS into ON
// - Mode query returns mode in effect
// - Error query returns, clears register, summary
`timescale 1ns/1ps
`include "emc_map.svh"
module emc_core (
   input wire logic mclk,
   input wire logic rst,
   input wire logic defaults_apply,
   input wire logic mask_wr,
   input wire logic [`EMC_ERR_W-1:0] mask_wdata,
   output logic [`EMC_ERR_W-1:0] error_enable_mask,
   input wire logic [`EMC_ERR_W-1:0] err_event,
   input wire logic err_query,
   output logic [`EMC_ERR_W-1:0] err_value,
   output logic err_value_valid,
   output logic [7:0] status_byte,
   input wire logic eoi_wr,
   input wire logic [1:0] eoi_wdata,
   output emc_pkg::emc_eoi_mode_t eoi_mode_q,
   input wire logic ascii_format,
   input wire logic recall_active,
   input wire logic multi_reading,
   input wire logic high_speed,
   input wire logic rd_valid,
   output logic rd_ready,
   input wire emc_pkg::emc_rd_byte_t rd_in,
   output logic out_valid,
   input wire logic out_ready,
   output emc_pkg::emc_out_byte_t out_byte
);
   import emc_pkg::*;

   // -------------------------------------------------------------
   // Error register and mask
   // -------------------------------------------------------------
   // Bit positions: 0 hardware, 1 calibration, 2 trigger too fast,
   // 3 syntax, 4 remote forbidden, 5 undefined parameter, 6 out of
   // range, 7 memory, 8 overload, 9 out of cal, 10 cal required,
   // 11 settings conflict, 12 math, 13 subprogram, 14 system.
   logic [`EMC_ERR_W-1:0] err_reg;
   logic [`EMC_ERR_W-1:0] next_err;
   logic [`EMC_ERR_W-1:0] next_mask;
   emc_eoi_mode_t eoi_mode;
   emc_eoi_mode_t next_eoi_mode;
   wire eoi_code_ok = (eoi_wdata != 2'h3);

   // A query clears, but an error landing in the same cycle survives
   assign next_err = err_event |
      (err_query ? `EMC_ERR_CLEAR : err_reg);
   // Defaults outrank a write issued in the same cycle
   assign next_mask = defaults_apply ? `EMC_MASK_RESET :
      (mask_wr ? mask_wdata : error_enable_mask);
   assign next_eoi_mode = defaults_apply ? EMC_EOI_ALWAYS :
      ((eoi_wr && eoi_code_ok) ? emc_eoi_mode_t'(eoi_wdata) :
      eoi_mode);

   // Error and mask registers; mask is readable as-is
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         err_reg <= `EMC_ERR_CLEAR;
         error_enable_mask <= `EMC_MASK_RESET;
         eoi_mode <= EMC_EOI_OFF;
      end else begin
         err_reg <= next_err;
         error_enable_mask <= next_mask;
         eoi_mode <= next_eoi_mode;
      end
   end

   // Query answer is the value before the clear, one cycle later
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         err_value <= `EMC_ERR_CLEAR;
         err_value_valid <= 1'b0;
      end else begin
         err_value_valid <= err_query;
         if (err_query) begin
            err_value <= err_reg;
         end
      end
   end

   // -------------------------------------------------------------
   // Summary bit
   // -------------------------------------------------------------
   // Combinational from both registers so a mask write takes hold at
   // once; the masked-off bits stay latched for a later query.
   wire summary_err =
      |(err_reg & error_enable_mask);
   always_comb begin
      status_byte = 8'h00;
      status_byte[`EMC_STATUS_ERR_BIT] = summary_err;
   end

   // -------------------------------------------------------------
   // Effective end-or-identify mode
   // -------------------------------------------------------------
   emc_eoi_mode_t eoi_eff;
   wire hs_demote = high_speed && (eoi_mode == EMC_EOI_ALWAYS);
   wire emc_eoi_mode_t next_eff = hs_demote ? EMC_EOI_ON : eoi_mode;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         eoi_eff <= EMC_EOI_OFF;
      end else begin
         eoi_eff <= next_eff;
      end
   end
   assign eoi_mode_q = eoi_eff;

   // -------------------------------------------------------------
   // Reading framer
   // -------------------------------------------------------------
   emc_state_t state;
   emc_state_t next_state;
   logic term_eoi;
   logic push_valid;
   logic push_ready;
   emc_out_byte_t push_byte;

   // EOI decision for the final byte of the current reading
   wire final_eoi = (eoi_eff == EMC_EOI_ALWAYS) ||
      ((eoi_eff == EMC_EOI_ON) && (!multi_reading ||
      rd_in.last_reading));
   wire rd_final = rd_in.last_byte;
   // Commas only between recalled ASCII readings of one group
   wire use_comma = recall_active && !rd_in.last_reading;
   wire in_data = (state == EMC_ST_DATA);
   wire take = in_data && rd_valid && push_ready;

   // Only the data state draws from the reading source
   assign rd_ready = in_data && push_ready;

   // Byte offered to the buffer for each state
   always_comb begin
      push_valid = 1'b1;
      push_byte.data = rd_in.data;
      push_byte.eoi = 1'b0;
      unique case (state)
         EMC_ST_DATA: begin
            push_valid = rd_valid;
            // Binary readings carry EOI on their own last byte
            push_byte.eoi = rd_final && !ascii_format && final_eoi;
         end
         EMC_ST_COMMA: begin
            push_byte.data = `EMC_CHR_COMMA;
            push_byte.eoi = term_eoi;
         end
         EMC_ST_CR: begin
            push_byte.data = `EMC_CHR_CR;
         end
         EMC_ST_LF: begin
            push_byte.data = `EMC_CHR_LF;
            push_byte.eoi = term_eoi;
         end
         default: begin
            push_valid = 1'b0;
         end
      endcase
   end

   // Terminator sequencing after an ASCII reading's last byte
   always_comb begin
      next_state = state;
      unique case (state)
         EMC_ST_DATA: begin
            if (take && rd_final && ascii_format) begin
               next_state = use_comma ? EMC_ST_COMMA :
                  EMC_ST_CR;
            end
         end
         EMC_ST_COMMA: begin
            if (push_ready) begin
               next_state = EMC_ST_DATA;
            end
         end
         EMC_ST_CR: begin
            if (push_ready) begin
               next_state = EMC_ST_LF;
            end
         end
         EMC_ST_LF: begin
            if (push_ready) begin
               next_state = EMC_ST_DATA;
            end
         end
         default: begin
            next_state = EMC_ST_DATA;
         end
      endcase
   end

   // State and the held EOI for the terminator byte
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= EMC_ST_DATA;
         term_eoi <= 1'b0;
      end else begin
         state <= next_state;
         if (take && rd_final) begin
            term_eoi <= final_eoi;
         end
      end
   end

   // A stalled bus fills the buffer, which then holds the framer
   emc_buf2 #(
      .W($bits(emc_out_byte_t))
   ) u_buf (
      .mclk(mclk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_byte),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_byte)
   );

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   wire pushed = push_valid && push_ready;

   sequence s_cr_pushed;
      pushed && state == EMC_ST_CR;
   endsequence
   sequence s_lf_follows;
      ##[1:40] (pushed && state == EMC_ST_LF);
   endsequence

   chk_err_latch_all: assert property ((|err_event) |=>
      ((err_reg & $past(err_event)) == $past(err_event)))
      else $error("error event not latched");
   chk_mask_gates_summary: assert property (
      mask_wr && !defaults_apply && mask_wdata == `EMC_ERR_CLEAR |=>
      !status_byte[`EMC_STATUS_ERR_BIT])
      else $error("summary set under empty mask");
   chk_mask_reevaluate: assert property (
      mask_wr && !defaults_apply && |(mask_wdata & err_reg) &&
      !err_query |=> status_byte[`EMC_STATUS_ERR_BIT])
      else $error("summary not raised by mask write");
   chk_defaults_values: assert property (defaults_apply |=>
      error_enable_mask == `EMC_MASK_RESET && eoi_mode == EMC_EOI_ALWAYS)
      else $error("defaults not applied");
   chk_query_clears: assert property (err_query && err_event ==
      `EMC_ERR_CLEAR |=> err_reg == `EMC_ERR_CLEAR &&
      !status_byte[`EMC_STATUS_ERR_BIT] && err_value == $past(err_reg))
      else $error("error query did not clear");
   chk_eoi_off_quiet: assert property (
      pushed && eoi_eff == EMC_EOI_OFF && state == EMC_ST_DATA |->
      !push_byte.eoi)
      else $error("EOI sent in mode off");
   chk_eoi_always_final: assert property (take && rd_final &&
      !ascii_format && eoi_eff == EMC_EOI_ALWAYS |-> push_byte.eoi)
      else $error("EOI missing in mode always");
   chk_hs_demotes: assert property (high_speed && eoi_mode ==
      EMC_EOI_ALWAYS |=> eoi_mode_q == EMC_EOI_ON)
      else $error("high speed did not demote mode");
   chk_crlf_pair: assert property (s_cr_pushed |-> s_lf_follows)
      else $error("cr not followed by lf");
   chk_comma_recall: assert property (
      take && rd_final && ascii_format && !recall_active |=>
      state == EMC_ST_CR)
      else $error("comma outside recall");

   // Mode ON with several readings: no EOI before the last one
   chk_eoi_on_multi: assert property (
      take && rd_final && !ascii_format && eoi_eff == EMC_EOI_ON &&
      multi_reading && !rd_in.last_reading |-> !push_byte.eoi)
      else $error("EOI before last reading in mode on");
   // Mode ON with a single reading: its terminator carries EOI
   chk_eoi_on_single: assert property (
      take && rd_final && eoi_eff == EMC_EOI_ON && !multi_reading |=>
      term_eoi)
      else $error("EOI dropped for single reading");
   // Recalled ASCII group: a comma follows each inner reading
   chk_comma_group: assert property (
      take && rd_final && ascii_format && use_comma |=>
      state == EMC_ST_COMMA)
      else $error("comma missing in recalled group");
   // Mask query answer is the value last written
   chk_mask_query: assert property (
      mask_wr && !defaults_apply |=> error_enable_mask == $past(mask_wdata))
      else $error("mask query differs from write");
   // Mode query shows the stored mode while high speed is idle
   chk_mode_query: assert property (
      !high_speed |=> eoi_mode_q == $past(eoi_mode))
      else $error("mode query differs from stored mode");
endmodule

/* core/emc_map.svh */
// Widths, reset values, codes and characters of the error mask block
`ifndef EMC_MAP_SVH
`define EMC_MAP_SVH
// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define EMC_ERR_W 15
`define EMC_MASK_RESET 15'h7fff
`define EMC_ERR_CLEAR 15'h0000
`define EMC_STATUS_ERR_BIT 5
// ----------------------------------------------------------------
// End-or-identify mode codes
// ----------------------------------------------------------------
`define EMC_EOI_OFF 2'h0
`define EMC_EOI_ON 2'h1
`define EMC_EOI_ALWAYS 2'h2
// ----------------------------------------------------------------
// Framing characters
// ----------------------------------------------------------------
`define EMC_CHR_COMMA 8'h2c
`define EMC_CHR_CR 8'h0d
`define EMC_CHR_LF 8'h0a
// ----------------------------------------------------------------
// Framer state codes, one-hot
// ----------------------------------------------------------------
`define EMC_ST_DATA 4'h1
`define EMC_ST_COMMA 4'h2
`define EMC_ST_CR 4'h4
`define EMC_ST_LF 4'h8
`endif

/* core/emc_pkg.sv */
// Types shared by the error mask and end-of-message block
`include "emc_map.svh"
package emc_pkg;
   typedef enum logic [1:0] {
      EMC_EOI_OFF = `EMC_EOI_OFF,
      EMC_EOI_ON = `EMC_EOI_ON,
      EMC_EOI_ALWAYS = `EMC_EOI_ALWAYS
   } emc_eoi_mode_t;

   typedef enum logic [3:0] {
      EMC_ST_DATA = `EMC_ST_DATA,
      EMC_ST_COMMA = `EMC_ST_COMMA,
      EMC_ST_CR = `EMC_ST_CR,
      EMC_ST_LF = `EMC_ST_LF
   } emc_state_t;

   // One byte of a reading as offered by the measurement side
   typedef struct packed {
      logic [7:0] data;
      logic last_byte;
      logic last_reading;
   } emc_rd_byte_t;

   // One byte as handed to the bus, with its end-or-identify flag
   typedef struct packed {
      logic [7:0] data;
      logic eoi;
   } emc_out_byte_t;
endpackage

/* core/emc_buf2.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module emc_buf2 #(
   parameter int W = 9
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] slot0;
   logic [W-1:0] slot1;
   logic [1:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Full and empty follow the count only
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = slot0;

   // Slot 0 is always the head; slot 1 shifts down on a pop
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         slot0 <= '0;
         slot1 <= '0;
         count <= 2'h0;
      end else begin
         if (pop) begin
            slot0 <= (count == 2'h2) ? slot1 : in_data;
         end else if (push && count == 2'h0) begin
            slot0 <= in_data;
         end
         if (push && ((count == 2'h1 && !pop) || count == 2'h2)) begin
            slot1 <= in_data;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_buf_noloss: assert property (pop && !push |=> count == $past(count)
      - 2'h1) else $error("buffer count wrong after pop");
endmodule

/* tb/emc_ctrl_model.sv */
// Bus controller model that takes framed bytes with stalls
`timescale 1ns/1ps
module emc_ctrl_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic hold,
   input wire logic slow,
   input wire logic out_valid,
   input wire emc_pkg::emc_out_byte_t out_byte,
   output logic out_ready
);
   import emc_pkg::*;
   logic [1:0] ph;
   logic [8:0] got[$];
   // ----------------------------------------------------------------
   // Acceptance
   // ----------------------------------------------------------------
   // Slow mode takes one byte in four so the buffer backs up
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ph <= 2'h0;
      end else begin
         ph <= ph + 2'h1;
      end
   end
   assign out_ready = !hold && !(slow && ph != 2'h0);
   // Record every byte taken, with its end flag
   always @(posedge mclk) begin
      if (!rst && out_valid && out_ready) begin
         got.push_back(out_byte);
      end
   end
endmodule

/* tb/tb.sv */
// Self-checking bench for the error mask and reading framer
`timescale 1ns/1ps
`include "emc_map.svh"
module tb;
   import emc_pkg::*;
   logic mclk = 0, rst = 1, defaults_apply = 0, mask_wr = 0, eoi_wr = 0;
   logic err_query = 0, ascii_format = 0, recall_active = 0;
   logic multi_reading = 0, high_speed = 0, rd_valid = 0, hold = 0;
   logic slow = 1;
   logic [14:0] mask_wdata = 0, err_event = 0, error_enable_mask, err_value;
   logic [1:0] eoi_wdata = 0, mode = 0;
   logic err_value_valid, rd_ready, out_valid, out_ready;
   logic [7:0] status_byte;
   emc_rd_byte_t rd_in = '0;
   emc_out_byte_t out_byte;
   emc_eoi_mode_t eoi_mode_q;
   int error_cnt = 0, compares = 0;
   logic [8:0] expq[$];
   // ----------------------------------------------------------------
   // Instances and clock
   // ----------------------------------------------------------------
   emc_core emc_core_inst (.mclk(mclk), .rst(rst),
      .defaults_apply(defaults_apply), .mask_wr(mask_wr),
      .mask_wdata(mask_wdata), .error_enable_mask(error_enable_mask),
      .err_event(err_event), .err_query(err_query), .err_value(err_value),
      .err_value_valid(err_value_valid), .status_byte(status_byte),
      .eoi_wr(eoi_wr), .eoi_wdata(eoi_wdata), .eoi_mode_q(eoi_mode_q),
      .ascii_format(ascii_format), .recall_active(recall_active),
      .multi_reading(multi_reading), .high_speed(high_speed),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_in(rd_in),
      .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte));
   emc_ctrl_model emc_ctrl_model_inst (.mclk(mclk), .rst(rst), .hold(hold),
      .slow(slow), .out_valid(out_valid), .out_byte(out_byte),
      .out_ready(out_ready));
   always #50 mclk = ~mclk;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task test_done;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Kinds: 0 mask write, 1 mode write, 2 error query, 3 defaults
   task cmd(input int k, input logic [14:0] v);
      @(posedge mclk);
      mask_wr <= (k == 0 || k == 3);
      eoi_wr <= (k == 1);
      err_query <= (k == 2);
      defaults_apply <= (k == 3);
      mask_wdata <= v;
      eoi_wdata <= v[1:0];
      @(posedge mclk);
      {mask_wr, eoi_wr, err_query, defaults_apply} <= 4'h0;
      #1;
   endtask
   task ev(input int n);
      @(posedge mclk);
      err_event <= 15'h1 << n;
      @(posedge mclk);
      err_event <= 15'h0;
      #1;
   endtask
   // Ready only changes on edges, so the falling edge shows the take
   task send(input logic [7:0] b, input logic lb, input logic lr);
      int n;
      n = 0;
      @(posedge mclk);
      rd_valid <= 1'b1;
      rd_in <= {b, lb, lr};
      @(negedge mclk);
      while (!rd_ready && n < 200) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 200) chk("rd_ready", 0, 1);
      @(posedge mclk);
      rd_valid <= 1'b0;
   endtask
   function logic eoi_exp(input logic lr);
      logic [1:0] m;
      m = (mode == `EMC_EOI_ALWAYS && high_speed) ? `EMC_EOI_ON : mode;
      return m == `EMC_EOI_ALWAYS ||
         (m == `EMC_EOI_ON && (!multi_reading || lr));
   endfunction
   // Two-byte reading; expected framing worked out alongside
   task rdg(input logic [7:0] b, input logic lr);
      send(b, 1'b0, lr);
      send(b + 8'h1, 1'b1, lr);
      expq.push_back({b, 1'b0});
      if (!ascii_format) begin
         expq.push_back({b + 8'h1, eoi_exp(lr)});
      end else begin
         expq.push_back({b + 8'h1, 1'b0});
         if (recall_active && !lr) begin
            expq.push_back({`EMC_CHR_COMMA, eoi_exp(lr)});
         end else begin
            expq.push_back({`EMC_CHR_CR, 1'b0});
            expq.push_back({`EMC_CHR_LF, eoi_exp(lr)});
         end
      end
   endtask
   task flush;
      int n;
      n = 0;
      while (emc_ctrl_model_inst.got.size() < expq.size() && n < 500) begin
         @(posedge mclk);
         n++;
      end
      chk("count", emc_ctrl_model_inst.got.size(), expq.size());
      foreach (expq[i]) begin
         chk("byte", emc_ctrl_model_inst.got[i], expq[i]);
      end
      expq.delete();
      emc_ctrl_model_inst.got.delete();
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   // Watchdog sized well past the expected run of under a thousand cycles
   initial begin
      #2000000;
      error_cnt++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("mask", error_enable_mask, `EMC_MASK_RESET);
      chk("mode", eoi_mode_q, `EMC_EOI_OFF);
      chk("status", status_byte, 8'h00);
      for (int n = 0; n < 15; n++) begin
         cmd(0, 15'h0);
         ev(n);
         chk("status", status_byte, 8'h00);
         cmd(0, 15'h7fff ^ (15'h1 << n));
         chk("mask", error_enable_mask, 15'h7fff ^ (15'h1 << n));
         chk("status", status_byte, 8'h00);
         cmd(0, 15'h1 << n);
         chk("status", status_byte, 8'h20);
         cmd(2, 15'h0);
         chk("valid", err_value_valid, 1'b1);
         chk("err", err_value, 15'h1 << n);
         chk("status", status_byte, 8'h00);
      end
      ev(3);
      ev(12);
      cmd(2, 15'h0);
      chk("err", err_value, 15'h1008);
      cmd(3, 15'h0);
      chk("mask", error_enable_mask, `EMC_MASK_RESET);
      @(posedge mclk);
      #1;
      chk("mode", eoi_mode_q, `EMC_EOI_ALWAYS);
      for (int m = 0; m < 4; m++) begin
         cmd(1, m);
         @(posedge mclk);
         #1;
         if (m < 3) mode = m;
         chk("mode", eoi_mode_q, mode);
      end
      // Every mode against single, recalled, direct and binary groups
      for (int m = 0; m < 3; m++) begin
         cmd(1, m);
         mode = m;
         for (int c = 0; c < 4; c++) begin
            @(posedge mclk);
            ascii_format <= (c != 3);
            recall_active <= (c == 1 || c == 3);
            multi_reading <= (c != 0);
            @(posedge mclk);
            rdg(8'h31, 1'b0);
            rdg(8'h41, 1'b1);
            flush();
         end
      end
      @(posedge mclk);
      high_speed <= 1'b1;
      ascii_format <= 1'b1;
      recall_active <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("mode", eoi_mode_q, `EMC_EOI_ON);
      rdg(8'h31, 1'b0);
      rdg(8'h41, 1'b1);
      flush();
      high_speed <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("mode", eoi_mode_q, `EMC_EOI_ALWAYS);
      // Receiver stalls: buffer fills, input refused, nothing lost
      @(posedge mclk);
      hold <= 1'b1;
      ascii_format <= 1'b0;
      multi_reading <= 1'b0;
      send(8'ha0, 1'b0, 1'b1);
      send(8'ha1, 1'b0, 1'b1);
      repeat (2) @(negedge mclk);
      chk("rd_ready", rd_ready, 1'b0);
      @(posedge mclk);
      hold <= 1'b0;
      send(8'ha2, 1'b1, 1'b1);
      expq = '{{8'ha0, 1'b0}, {8'ha1, 1'b0}, {8'ha2, 1'b1}};
      flush();
      test_done();
   end
endmodule
